// ==== design/ccri_cfg.svh ====
// register map, field positions, reset values for the camera crop/resize/event block
`ifndef CCRI_CFG_SVH
`define CCRI_CFG_SVH
// register offsets (byte addresses, one 32-bit word each)
`define CCRI_OFS_CTRL 8'h00
`define CCRI_OFS_RAW 8'h04
`define CCRI_OFS_ENABLE 8'h08
`define CCRI_OFS_MASKED 8'h0c
`define CCRI_OFS_CLEAR 8'h10
`define CCRI_OFS_START 8'h14
`define CCRI_OFS_SIZE 8'h18
// control register fields
`define CCRI_CTL_CAPTURE 0
`define CCRI_CTL_EMB_SYNC 1
`define CCRI_CTL_PCLK_POL 2
`define CCRI_CTL_HS_POL 3
`define CCRI_CTL_VS_POL 4
`define CCRI_CTL_CROP_EN 5
`define CCRI_CTL_WIDTH_LSB 6
`define CCRI_CTL_LINE_HALF 8
`define CCRI_CTL_LINE_ODD 9
`define CCRI_CTL_BYTE_LSB 10
`define CCRI_CTL_BYTE_ODD 12
// event bit positions, shared by raw, enable, masked and clear registers
`define CCRI_EVT_FRAME 0
`define CCRI_EVT_OVR 1
`define CCRI_EVT_ERR 2
`define CCRI_EVT_VSYNC 3
`define CCRI_EVT_LINE 4
// window fields
`define CCRI_WIN_X_LSB 0
`define CCRI_WIN_Y_LSB 16
// reset values
`define CCRI_RST_CTRL 32'h0000_0000
`define CCRI_RST_START 32'h0000_0000
`define CCRI_RST_SIZE 32'h0000_0000
`define CCRI_RST_EVT 5'h00
// data width select codes
`define CCRI_WID_8 2'h0
`define CCRI_WID_10 2'h1
`define CCRI_WID_12 2'h2
`define CCRI_WID_14 2'h3
// byte select codes
`define CCRI_BYTE_ALL 2'h0
`define CCRI_BYTE_HALF 2'h1
`define CCRI_BYTE_QUARTER 2'h2
`define CCRI_BYTE_TWO4 2'h3
`endif

// ==== design/ccri_pkg.sv ====
// types shared by the camera crop/resize/event block
package ccri_pkg;
    // frame capture sequencing, one-hot
    typedef enum logic [2:0] {
        FR_IDLE = 3'b001,
        FR_WAIT = 3'b010,
        FR_RUN = 3'b100
    } ccri_frame_type;
    // one kept sample handed to the packer
    typedef struct packed {
        logic valid;
        logic [13:0] data;
    } ccri_pix_type;
    // sync markers from the embedded code decoder
    typedef struct packed {
        logic frame_start;
        logic frame_end;
        logic line_start;
        logic line_end;
    } ccri_emb_type;
endpackage

// ==== design/ccri_top.sv ====
// camera capture window, line/byte decimation and event/interrupt registers
//
// Functional notes
// R1: window start register drops earlier pixels
// R2: window width in clocks, height in lines
// R3: keep all lines or odd/even only
// R4: keep all, alternate, one-of-four, two-of-four bytes
// R5: software uses quarter only with 8-bit pixels
// R6: alternate bytes on YCbCr keep luma only
// R7: five events: line, frame, overrun, sync, error
// R8: order error only in embedded sync mode
// R9: global irq is OR of enabled events
// R10: enable register and raw status register
// R11: masked status equals raw AND enable
// R12: hardware sync mode uses four events only
// R13: sample 8, 10, 12 or 14 bits
// R14: embedded mode uses eight data bits only
// R15: keeps working while processor sleeps
// R16: freeze stops operation, registers kept
// R17: hardware frame sync event without capture
// R18: raw flags sticky until software clears
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "ccri_cfg.svh"

module ccri_top
    import ccri_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pixel_clock_in,
    input wire logic hsync_in,
    input wire logic vsync_in,
    input wire logic [13:0] pixel_data_in,
    input wire ccri_emb_type emb_sync,
    input wire logic overrun_in,
    input wire logic clk_freeze,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output ccri_pix_type pix_out,
    output logic global_irq
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [16:0] pin_s1_q; // first stage, read only by second stage
    logic [16:0] pin_s2_q; // second stage, safe to use
    logic pclk_d1_q; // delayed copy for edge finding
    // all pins pass two flops; frozen clocks hold them too
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_s1_q <= 17'h00000;
            pin_s2_q <= 17'h00000;
            pclk_d1_q <= 1'b0;
        end else if (!clk_freeze) begin // see R16
            pin_s1_q <= {pixel_clock_in, hsync_in, vsync_in, pixel_data_in};
            pin_s2_q <= pin_s1_q;
            pclk_d1_q <= pin_s2_q[16];
        end
    end

    // ****************************************
    // register file
    // ****************************************
    logic [31:0] ctrl_q; // capture_control_reg
    logic [31:0] start_q; // crop_window_start
    logic [31:0] size_q; // crop_window_size
    logic [4:0] enable_q; // event_enable_reg
    logic [4:0] raw_q; // raw_event_status_reg
    logic [4:0] evt_set; // this cycle's event pulses
    logic [4:0] evt_clr; // software clear pulses
    logic [4:0] masked; // masked_event_status_reg
    logic emb_mode; // embedded_sync_select
    logic [1:0] width_sel; // data_width_select
    logic [1:0] byte_sel; // byte decimation mode

    assign emb_mode = ctrl_q[`CCRI_CTL_EMB_SYNC];
    // embedded codes only exist on 8-bit buses
    assign width_sel = emb_mode ? `CCRI_WID_8 : ctrl_q[`CCRI_CTL_WIDTH_LSB +: 2]; // see R14
    assign byte_sel = ctrl_q[`CCRI_CTL_BYTE_LSB +: 2];
    assign masked = raw_q & enable_q; // see R11
    assign global_irq = |masked; // see R9
    assign evt_clr = (reg_wr && reg_addr == `CCRI_OFS_CLEAR) ? reg_wdata[4:0] : 5'h00;

    // writable registers; writes while frozen are dropped
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_q <= `CCRI_RST_CTRL;
            start_q <= `CCRI_RST_START;
            size_q <= `CCRI_RST_SIZE;
            enable_q <= `CCRI_RST_EVT;
        end else if (reg_wr && !clk_freeze) begin // see R16
            if (reg_addr == `CCRI_OFS_CTRL) begin
                ctrl_q <= reg_wdata;
            end else if (reg_addr == `CCRI_OFS_ENABLE) begin
                enable_q <= reg_wdata[4:0]; // see R10
            end else if (reg_addr == `CCRI_OFS_START) begin
                start_q <= reg_wdata; // see R1
            end else if (reg_addr == `CCRI_OFS_SIZE) begin
                size_q <= reg_wdata; // see R2
            end
        end
    end

    // sticky flags: a set in the clear cycle wins so no event is lost
    always_ff @(posedge core_clk) begin
        if (reset) begin
            raw_q <= `CCRI_RST_EVT;
        end else if (!clk_freeze) begin
            raw_q <= (raw_q & ~evt_clr) | evt_set; // see R18
        end
    end

    // read data one cycle after the strobe; unmapped and write-only read zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd && !clk_freeze) begin
            if (reg_addr == `CCRI_OFS_CTRL) begin
                reg_rdata <= ctrl_q;
            end else if (reg_addr == `CCRI_OFS_RAW) begin
                reg_rdata <= {27'h0000000, raw_q}; // see R10
            end else if (reg_addr == `CCRI_OFS_ENABLE) begin
                reg_rdata <= {27'h0000000, enable_q};
            end else if (reg_addr == `CCRI_OFS_MASKED) begin
                reg_rdata <= {27'h0000000, masked}; // see R11
            end else if (reg_addr == `CCRI_OFS_START) begin
                reg_rdata <= start_q;
            end else if (reg_addr == `CCRI_OFS_SIZE) begin
                reg_rdata <= size_q;
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // sync tracking
    // ****************************************
    logic pclk_edge; // chosen pixel clock edge, one cycle pulse
    logic hw_line_act; // line valid from the pin, polarity applied
    logic hw_frame_act; // frame valid from the pin, polarity applied
    logic emb_line_q; // inside a line per embedded codes
    logic emb_frame_q; // inside a frame per embedded codes
    logic emb_err; // codes out of order
    logic line_act; // line valid for the selected mode
    logic frame_act; // frame valid for the selected mode
    logic line_act_q; // previous value, for edges
    logic frame_act_q; // previous value, for edges
    logic frame_rise; // frame start pulse
    logic frame_fall; // frame end pulse
    logic line_fall; // line end pulse

    assign pclk_edge = ctrl_q[`CCRI_CTL_PCLK_POL] ? (pin_s2_q[16] & ~pclk_d1_q)
                                                  : (~pin_s2_q[16] & pclk_d1_q);
    // hsync/vsync pins play no part in embedded mode
    assign hw_line_act = pin_s2_q[15] == ctrl_q[`CCRI_CTL_HS_POL]; // see R14
    assign hw_frame_act = pin_s2_q[14] == ctrl_q[`CCRI_CTL_VS_POL];
    assign line_act = emb_mode ? emb_line_q : hw_line_act;
    assign frame_act = emb_mode ? emb_frame_q : hw_frame_act;
    assign frame_rise = frame_act & ~frame_act_q;
    assign frame_fall = ~frame_act & frame_act_q;
    assign line_fall = ~line_act & line_act_q;
    // frame start inside a frame, line start inside a line or outside a frame, ends without a start
    assign emb_err = (emb_sync.frame_start & emb_frame_q)
                   | (emb_sync.frame_end & ~emb_frame_q)
                   | (emb_sync.line_start & (emb_line_q | ~emb_frame_q))
                   | (emb_sync.line_end & ~emb_line_q);

    // embedded marker state; when a start and an end come in the same cycle, the start wins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            emb_frame_q <= 1'b0;
            emb_line_q <= 1'b0;
        end else if (!clk_freeze) begin
            if (emb_sync.frame_start) begin
                emb_frame_q <= 1'b1;
            end else if (emb_sync.frame_end) begin
                emb_frame_q <= 1'b0;
            end
            if (emb_sync.line_start && emb_frame_q) begin
                emb_line_q <= 1'b1;
            end else if (emb_sync.line_end || emb_sync.frame_end) begin
                emb_line_q <= 1'b0;
            end
        end
    end

    // history of line/frame activity
    // reset polarity bits are 0, so idle pins read as active: history starts
    // active too, else a false frame start would raise the sync flag
    always_ff @(posedge core_clk) begin
        if (reset) begin
            line_act_q <= 1'b1;
            frame_act_q <= 1'b1;
        end else if (!clk_freeze) begin
            line_act_q <= line_act;
            frame_act_q <= frame_act;
        end
    end

    // ****************************************
    // capture sequencing
    // ****************************************
    ccri_frame_type state_q; // capture state
    logic running; // a frame is being captured

    assign running = state_q == FR_RUN;
    // capture waits for a frame start; clearing it lets the frame finish
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= FR_IDLE;
        end else if (!clk_freeze) begin
            case (state_q)
                FR_IDLE: begin
                    if (ctrl_q[`CCRI_CTL_CAPTURE]) begin
                        state_q <= FR_WAIT;
                    end
                end
                FR_WAIT: begin
                    if (!ctrl_q[`CCRI_CTL_CAPTURE]) begin
                        state_q <= FR_IDLE;
                    end else if (frame_rise) begin
                        state_q <= FR_RUN;
                    end
                end
                FR_RUN: begin
                    if (frame_fall) begin
                        state_q <= ctrl_q[`CCRI_CTL_CAPTURE] ? FR_WAIT : FR_IDLE;
                    end
                end
                default: begin
                    state_q <= FR_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // events
    // ****************************************
    // hardware mode reports frame sync even when capture is off
    always_comb begin
        evt_set = 5'h00;
        evt_set[`CCRI_EVT_LINE] = running & line_fall; // see R7
        evt_set[`CCRI_EVT_FRAME] = running & frame_fall;
        evt_set[`CCRI_EVT_OVR] = running & overrun_in;
        evt_set[`CCRI_EVT_VSYNC] = frame_rise & (~emb_mode | ~state_q[0]); // see R17
        // the error source is dead in hardware sync mode
        evt_set[`CCRI_EVT_ERR] = emb_mode & emb_err; // see R8 R12
        if (clk_freeze) begin
            evt_set = 5'h00; // see R16
        end
    end

    // ****************************************
    // crop and decimation
    // ****************************************
    logic [13:0] x_q; // pixel clocks since line start
    logic [13:0] y_q; // lines since frame start
    logic [14:0] x_end; // first column past the window
    logic [14:0] y_end; // first line past the window
    logic in_win; // current sample is inside the window
    logic line_keep; // current line survives line selection
    logic byte_keep; // current byte survives byte selection
    logic take; // sample this pixel edge

    assign x_end = {1'b0, start_q[`CCRI_WIN_X_LSB +: 14]} + {1'b0, size_q[`CCRI_WIN_X_LSB +: 14]};
    assign y_end = {2'b00, start_q[`CCRI_WIN_Y_LSB +: 13]} + {1'b0, size_q[`CCRI_WIN_Y_LSB +: 14]};
    // a disabled crop passes the whole frame
    assign in_win = !ctrl_q[`CCRI_CTL_CROP_EN]
                  || (x_q >= start_q[`CCRI_WIN_X_LSB +: 14] && {1'b0, x_q} < x_end
                  && y_q >= {1'b0, start_q[`CCRI_WIN_Y_LSB +: 13]}
                  && {1'b0, y_q} < y_end); // see R1 R2
    assign line_keep = !ctrl_q[`CCRI_CTL_LINE_HALF]
                     || (y_q[0] == ctrl_q[`CCRI_CTL_LINE_ODD]); // see R3
    assign take = running & line_act & pclk_edge & ~clk_freeze;

    // byte phase counts from line start; odd phase of Cb Y Cr Y is luma
    always_comb begin
        case (byte_sel)
            `CCRI_BYTE_ALL: byte_keep = 1'b1; // see R4
            `CCRI_BYTE_HALF: byte_keep = x_q[0] == ctrl_q[`CCRI_CTL_BYTE_ODD]; // see R6
            // quarter rate only makes sense for 8-bit pixels, left to software
            `CCRI_BYTE_QUARTER: byte_keep = x_q[1:0] == {1'b0, ctrl_q[`CCRI_CTL_BYTE_ODD]};
            default: byte_keep = x_q[1] == ctrl_q[`CCRI_CTL_BYTE_ODD];
        endcase
    end

    // position counters follow the incoming raster
    always_ff @(posedge core_clk) begin
        if (reset) begin
            x_q <= 14'h0000;
            y_q <= 14'h0000;
        end else if (!clk_freeze) begin
            if (frame_rise) begin
                y_q <= 14'h0000;
            end else if (line_fall && frame_act) begin
                y_q <= y_q + 14'h0001;
            end
            if (!line_act) begin
                x_q <= 14'h0000;
            end else if (take) begin
                x_q <= x_q + 14'h0001;
            end
        end
    end

    // kept sample, masked to the selected bus width
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pix_out <= '0;
        end else if (!clk_freeze) begin
            pix_out.valid <= take & in_win & line_keep & byte_keep;
            case (width_sel)
                `CCRI_WID_8: pix_out.data <= {6'h00, pin_s2_q[7:0]}; // see R13
                `CCRI_WID_10: pix_out.data <= {4'h0, pin_s2_q[9:0]};
                `CCRI_WID_12: pix_out.data <= {2'h0, pin_s2_q[11:0]};
                default: pix_out.data <= pin_s2_q[13:0];
            endcase
        end
    end

    // sleep of the processor does not touch this block: it has no sleep input
    // and keeps running on core_clk, raising global_irq to wake it (see R15)

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    irq_from_mask_a: assert property ( // see R9
        (|(raw_q & enable_q)) |-> global_irq) else $error("enabled event without irq");
    masked_read_a: assert property ( // see R11
        reg_rd && reg_addr == `CCRI_OFS_MASKED && !clk_freeze
        |=> reg_rdata[4:0] == $past(raw_q & enable_q)) else $error("masked read wrong");
    raw_read_a: assert property ( // see R10
        reg_rd && reg_addr == `CCRI_OFS_RAW && !clk_freeze
        |=> reg_rdata == {27'h0000000, $past(raw_q)}) else $error("raw read wrong");
    err_only_emb_a: assert property ( // see R8
        $rose(raw_q[`CCRI_EVT_ERR]) |-> $past(emb_mode)) else $error("error event in hw mode");
    flag_sticky_a: assert property ( // see R18
        raw_q[`CCRI_EVT_LINE] && !evt_clr[`CCRI_EVT_LINE] && !clk_freeze
        |=> raw_q[`CCRI_EVT_LINE]) else $error("line flag lost");
    freeze_hold_a: assert property ( // see R16
        clk_freeze |=> $stable(raw_q) && $stable(ctrl_q) && $stable(x_q))
        else $error("frozen state moved");
    vsync_no_cap_a: assert property ( // see R17
        !emb_mode && frame_rise && !clk_freeze |=> raw_q[`CCRI_EVT_VSYNC])
        else $error("frame sync missed");
    line_select_a: assert property ( // see R3
        pix_out.valid && $past(ctrl_q[`CCRI_CTL_LINE_HALF])
        |-> $past(y_q[0]) == $past(ctrl_q[`CCRI_CTL_LINE_ODD])) else $error("dropped line kept");
    width_mask_a: assert property ( // see R13
        pix_out.valid && $past(width_sel) == `CCRI_WID_8 |-> pix_out.data[13:8] == 6'h00)
        else $error("upper bits in 8-bit mode");
    crop_left_a: assert property ( // see R1
        pix_out.valid && $past(ctrl_q[`CCRI_CTL_CROP_EN])
        |-> $past(x_q) >= $past(start_q[`CCRI_WIN_X_LSB +: 14])) else $error("pixel before window");
    crop_right_a: assert property ( // see R2
        pix_out.valid && $past(ctrl_q[`CCRI_CTL_CROP_EN])
        |-> {1'b0, $past(x_q)} < $past(x_end)) else $error("pixel past window");
    byte_half_a: assert property ( // see R4
        pix_out.valid && $past(byte_sel) == `CCRI_BYTE_HALF
        |-> $past(x_q[0]) == $past(ctrl_q[`CCRI_CTL_BYTE_ODD])) else $error("dropped byte kept");
    frame_end_evt_a: assert property ( // see R7
        running && frame_fall && !clk_freeze |=> raw_q[`CCRI_EVT_FRAME])
        else $error("frame end missed");
endmodule // ccri_top
`default_nettype wire

// ==== test/ccri_cam_model.sv ====
// camera-side model: pixel clock, line and frame sync, pixel data
`timescale 1ns/1ns
`default_nettype none

module ccri_cam_model (
    output var logic pclk,
    output var logic hsync,
    output var logic vsync,
    output var logic [13:0] data
);
    // ********************
    // camera pins
    // ********************
    // pclk stands still low between frames; syncs are active high
    initial begin
        pclk = 1'b0;
        hsync = 1'b0;
        vsync = 1'b0;
        data = 14'h0000;
    end

    // one 320 ns pixel period; data moves on the falling edge only
    task automatic tick(input logic [13:0] d);
        data = d;
        #160 pclk = 1'b1;
        #160 pclk = 1'b0;
    endtask

    // blank period: data toggles so a stale value is never mistaken for a pixel
    task automatic gap();
        tick(~data);
        tick(~data);
    endtask

    // whole frame; each pixel carries {line, column} so the bench can trace it
    task automatic frame(input int lines, input int width);
        #7; // pin moves stay clear of the sampling clock edge
        vsync = 1'b1;
        gap();
        for (int y = 0; y < lines; y++) begin
            hsync = 1'b1;
            for (int x = 0; x < width; x++) begin
                tick({y[5:0], x[7:0]});
            end
            hsync = 1'b0;
            gap();
        end
        vsync = 1'b0;
        gap();
    endtask
endmodule // ccri_cam_model

`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the crop/resize/event block
`timescale 1ns/1ns
`default_nettype none
`include "ccri_cfg.svh"

module tb
    import ccri_pkg::*;
;
    localparam int LINES = 6; // small frame keeps the run short
    localparam int WIDTH = 12;
    logic core_clk, reset, pclk, hsync, vsync, overrun_in, clk_freeze, reg_wr, reg_rd;
    logic [13:0] pdata;
    ccri_emb_type emb_sync;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v, c, st, sz;
    ccri_pix_type pix_out;
    logic global_irq;
    logic [13:0] last_pix, exp_last;
    int fails, n_tests, n_kept, cyc, n0, n_exp;
    integer seed;

    ccri_top ccri_top_i (.core_clk(core_clk), .reset(reset), .pixel_clock_in(pclk),
        .hsync_in(hsync), .vsync_in(vsync), .pixel_data_in(pdata), .emb_sync(emb_sync),
        .overrun_in(overrun_in), .clk_freeze(clk_freeze), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pix_out(pix_out), .global_irq(global_irq));
    ccri_cam_model ccri_cam_model_i (.pclk(pclk), .hsync(hsync), .vsync(vsync), .data(pdata));

    // ********************
    // clock, counters, timeout
    // ********************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // kept samples are counted here; pulses last one cycle only
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (pix_out.valid === 1'b1) begin
            n_kept = n_kept + 1;
            last_pix = pix_out.data;
        end
        if (cyc == 40000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    // ********************
    // shared tasks
    // ********************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data appears in the cycle after the read edge and holds until the next read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic pulse_emb(input logic [3:0] e);
        @(posedge core_clk);
        emb_sync <= e;
        @(posedge core_clk);
        emb_sync <= 4'h0;
    endtask

    task automatic settle();
        repeat (40) @(posedge core_clk);
    endtask

    // expected count and last kept sample; byte phase is the column from 0
    task automatic expect_run();
        logic keep;
        n_exp = 0;
        exp_last = 14'h0000;
        for (int y = 0; y < LINES; y++) begin
            for (int x = 0; x < WIDTH; x++) begin
                keep = 1'b1;
                if (c[5] && (x < st[13:0] || x >= st[13:0] + sz[13:0])) keep = 1'b0;
                if (c[5] && (y < st[28:16] || y >= st[28:16] + sz[29:16])) keep = 1'b0;
                if (c[8] && y % 2 != c[9]) keep = 1'b0;
                if (c[11:10] == 2'h1 && x % 2 != c[12]) keep = 1'b0;
                if (c[11:10] == 2'h2 && x % 4 != c[12]) keep = 1'b0;
                if (c[11:10] == 2'h3 && (x / 2) % 2 != c[12]) keep = 1'b0;
                if (keep) begin
                    n_exp = n_exp + 1;
                    exp_last = {y[5:0], x[7:0]};
                end
            end
        end
        exp_last = exp_last & 14'((32'd1 << (8 + 2 * c[7:6])) - 1); // bus width
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        seed = 32'h7ac6;
        {reset, overrun_in, clk_freeze, reg_wr, reg_rd} = 5'h10;
        {reg_addr, reg_wdata, emb_sync} = '0;
        {fails, n_tests, n_kept, cyc} = '0;
        last_pix = 14'h0000;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        // every register reads zero after reset, the unmapped place too
        for (int a = 0; a < 8; a++) begin
            rd(8'(a * 4), v);
            chk("reset value", v, 32'h0);
        end
        // frames with random window and decimation; corner case first
        for (int i = 0; i < 5; i++) begin
            v = $random(seed);
            c = 32'h0000_001d | {19'h0, v[4:0], v[21:20], 6'h20};
            if (c[11:10] == 2'h2) c[7:6] = 2'h0; // quarter only with 8-bit pixels
            st = {3'h0, 13'(v[7:5] % LINES), 2'h0, 14'(v[11:8] % WIDTH)};
            sz = {2'h0, 14'(v[14:12] + 1), 2'h0, 14'(v[19:16] + 2)};
            if (i == 0) st = {3'h0, 13'(LINES - 1), 2'h0, 14'(WIDTH - 1)};
            if (i == 0) sz = 32'h0001_0001;
            wr(`CCRI_OFS_START, st);
            wr(`CCRI_OFS_SIZE, sz);
            wr(`CCRI_OFS_CTRL, c);
            expect_run();
            n0 = n_kept;
            fork
                ccri_cam_model_i.frame(LINES, WIDTH);
                if (i == 1) begin
                    repeat (200) @(posedge core_clk);
                    overrun_in <= 1'b1;
                    @(posedge core_clk);
                    overrun_in <= 1'b0;
                end
            join
            settle();
            chk("kept samples", n_kept - n0, n_exp);
            if (n_exp > 0) chk("last sample", last_pix, exp_last);
            rd(`CCRI_OFS_RAW, v);
            chk("raw after frame", v, (i == 1) ? 32'h1b : 32'h19);
            wr(`CCRI_OFS_CLEAR, 32'h1f);
        end
        // flags stay until cleared; mask and irq follow raw and enable
        wr(`CCRI_OFS_CTRL, 32'h0000_00dd);
        ccri_cam_model_i.frame(2, 4);
        settle();
        v = $random(seed);
        wr(`CCRI_OFS_ENABLE, v);
        rd(`CCRI_OFS_ENABLE, c);
        chk("enable", c, {27'h0, v[4:0]});
        rd(`CCRI_OFS_MASKED, c);
        chk("masked", c, {27'h0, v[4:0] & 5'h19});
        chk("irq", {31'h0, global_irq}, {31'h0, |(v[4:0] & 5'h19)});
        wr(`CCRI_OFS_ENABLE, 32'h10);
        #1; // let the new enable reach the irq before looking
        chk("irq line", {31'h0, global_irq}, 32'h1);
        rd(`CCRI_OFS_RAW, c);
        chk("sticky raw", c, 32'h19);
        wr(`CCRI_OFS_CLEAR, 32'h1f);
        rd(`CCRI_OFS_RAW, c);
        chk("cleared raw", c, 32'h0);
        chk("irq cleared", {31'h0, global_irq}, 32'h0);
        // frame sync still flagged with capture off
        wr(`CCRI_OFS_CTRL, 32'h0000_001c);
        ccri_cam_model_i.frame(2, 4);
        settle();
        wr(`CCRI_OFS_RAW, 32'h1f);
        rd(`CCRI_OFS_RAW, c);
        chk("sync without capture", c, 32'h08);
        wr(`CCRI_OFS_CLEAR, 32'h1f);
        // order fault: ignored in hardware mode, flagged in embedded mode
        wr(`CCRI_OFS_CTRL, 32'h0000_001d);
        pulse_emb(4'h1);
        settle();
        rd(`CCRI_OFS_RAW, c);
        chk("no error in hw mode", c, 32'h0);
        wr(`CCRI_OFS_CTRL, 32'h0000_0003);
        pulse_emb(4'h1);
        settle();
        rd(`CCRI_OFS_RAW, c);
        chk("order error", c, 32'h04);
        // frozen: access dropped, contents kept
        clk_freeze <= 1'b1;
        wr(`CCRI_OFS_ENABLE, 32'h1f);
        wr(`CCRI_OFS_CLEAR, 32'h1f);
        clk_freeze <= 1'b0;
        rd(`CCRI_OFS_ENABLE, c);
        chk("enable kept in freeze", c, 32'h10);
        rd(`CCRI_OFS_RAW, c);
        chk("raw kept in freeze", c, 32'h04);
        // embedded frame: sync flagged while armed, frame end while capturing
        wr(`CCRI_OFS_CLEAR, 32'h1f);
        pulse_emb(4'h8);
        pulse_emb(4'h4);
        settle();
        rd(`CCRI_OFS_RAW, c);
        chk("embedded frame", c, 32'h09);
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
